/* File: rtl/stx_pkg.sv */
// package: register map, field positions, states and shared helpers
package stx_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] STX_OFS_HOLD = 8'h00;  // transmit_holding
   localparam logic [7:0] STX_OFS_MODE = 8'h04;  // serial_format_mode
   localparam logic [7:0] STX_OFS_CTRL = 8'h08;  // control bits
   localparam logic [7:0] STX_OFS_STAT = 8'h0C;  // status flags
   localparam logic [7:0] STX_OFS_RATE = 8'h10;  // bit period divisor
   localparam logic [7:0] STX_OFS_RXD  = 8'h14;  // receive_holding
   // reset values
   localparam logic [7:0] STX_RST_HOLD = 8'hFF;
   localparam logic [7:0] STX_RST_MODE = 8'h00;
   localparam logic [7:0] STX_RST_CTRL = 8'h00;
   localparam logic [7:0] STX_RST_RATE = 8'h0F;
   localparam logic [7:0] STX_RST_RXD  = 8'h00;
   // serial_format_mode fields
   localparam int STX_M_SYNC = 7;  // 1 = clocked synchronous
   localparam int STX_M_CHR  = 6;  // char_length_select, 1 = 7 bits
   localparam int STX_M_PE   = 5;  // parity_enable_bit
   localparam int STX_M_ODD  = 4;  // 1 = odd parity
   localparam int STX_M_STOP = 3;  // 1 = two stop bits
   localparam int STX_M_MP   = 2;  // multidrop_format_select
   localparam int STX_M_CKSH = 1;  // baud_src_sel_hi
   localparam int STX_M_CKSL = 0;  // baud_src_sel_lo
   // control fields
   localparam int STX_C_TE   = 5;  // transmit_enable_bit
   localparam int STX_C_RE   = 4;  // receive enable
   localparam int STX_C_MPE  = 3;  // multidrop_global_enable
   localparam int STX_C_STBY = 1;  // standby request
   localparam int STX_C_MPBT = 0;  // multidrop bit to send
   // status fields
   localparam int STX_S_HEMP = 7;  // tx_holding_empty_flag
   localparam int STX_S_RXF  = 6;  // receive_holding full
   localparam int STX_S_FERR = 4;  // framing error
   localparam int STX_S_PERR = 3;  // parity error
   localparam int STX_S_TEND = 2;  // transmitter idle
   localparam int STX_S_MPB  = 1;  // received multidrop bit
   // prescaler masks for /1, /4, /16, /64
   localparam logic [5:0] STX_PRE_M1  = 6'h00;
   localparam logic [5:0] STX_PRE_M4  = 6'h03;
   localparam logic [5:0] STX_PRE_M16 = 6'h0F;
   localparam logic [5:0] STX_PRE_M64 = 6'h3F;

   // serial frame states, shared by both directions
   typedef enum logic [2:0] {
      STX_IDLE  = 3'b000,
      STX_START = 3'b001,
      STX_DATA  = 3'b010,
      STX_PAR   = 3'b011,
      STX_STOP1 = 3'b100,
      STX_STOP2 = 3'b101
   } stx_state_type;

   // parity bit over 7 or 8 data bits, even or odd
   function automatic logic stx_parity(input logic [7:0] d, input logic seven, input logic odd);
      stx_parity = (^d[6:0]) ^ (d[7] & ~seven) ^ odd;
   endfunction
endpackage

/* File: rtl/stx_rx.sv */
// asynchronous serial receiver feeding receive_holding
`timescale 1ns/100ps
module stx_rx
   import stx_pkg::*;
#(
   parameter int RATE_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              en,       // receive active, async only
   input  wire logic              pre_tick, // prescaled baud tick
   input  wire logic [RATE_W-1:0] rate,     // bit period minus one
   input  wire logic              seven,    // 7-bit characters
   input  wire logic              par_en,   // parity checked
   input  wire logic              odd,      // odd parity
   input  wire logic              mp_en,    // multidrop bit expected
   input  wire logic              rxd,      // serial input
   output logic                   done,     // one-cycle pulse per char
   output logic [7:0]             data,     // received character
   output logic                   perr,     // parity mismatch
   output logic                   ferr,     // first stop bit low
   output logic                   mpb       // received multidrop bit
);
   // whole receiver state
   typedef struct packed {
      stx_state_type     st;
      logic              prev;
      logic [RATE_W-1:0] cnt;
      logic [2:0]        bitn;
      logic [7:0]        sh;
      logic              done;
      logic              perr;
      logic              ferr;
      logic              mpb;
   } stx_rxs_type;

   stx_rxs_type s_q;  // registered state
   stx_rxs_type s_d;  // next state
   logic        samp; // sampling point of the current bit

   // frame sequencing, sampled mid-bit
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.prev = rxd;
      samp     = 1'b0;
      if (pre_tick && s_q.st != STX_IDLE) begin
         s_d.cnt = s_q.cnt + 1'b1;
         if (s_q.st == STX_START) begin
            samp = (s_q.cnt == (rate >> 1));
         end else begin
            samp = (s_q.cnt == rate);
         end
         if (samp) begin
            s_d.cnt = '0;
         end
      end
      case (s_q.st)
         STX_IDLE: begin
            // falling edge opens a frame
            if (s_q.prev && !rxd) begin
               s_d.st  = STX_START;
               s_d.cnt = '0;
            end
         end
         STX_START: begin
            // a glitch shorter than half a bit is dropped
            if (samp) begin
               s_d.st   = rxd ? STX_IDLE : STX_DATA;
               s_d.bitn = 3'h0;
            end
         end
         STX_DATA: begin
            if (samp) begin
               s_d.sh   = {rxd, s_q.sh[7:1]};
               s_d.bitn = s_q.bitn + 3'h1;
               if (s_q.bitn == (seven ? 3'h6 : 3'h7)) begin
                  // bit 7 stored as zero for short chars
                  if (seven) begin
                     s_d.sh = {1'b0, rxd, s_q.sh[7:2]};
                  end
                  s_d.st = (par_en || mp_en) ? STX_PAR : STX_STOP1;
               end
            end
         end
         STX_PAR: begin
            if (samp) begin
               s_d.mpb  = mp_en ? rxd : 1'b0;
               s_d.perr = par_en && (rxd != stx_parity(s_q.sh, seven, odd));
               s_d.st   = STX_STOP1;
            end
         end
         STX_STOP1: begin
            // only the first stop bit is checked; a low second
            // stop bit is then seen as the next start
            if (samp) begin
               s_d.ferr = !rxd;
               s_d.done = 1'b1;
               s_d.prev = 1'b1;
               s_d.st   = STX_IDLE;
            end
         end
         default: s_d.st = STX_IDLE;
      endcase
      if (!par_en) begin
         s_d.perr = s_d.st == STX_STOP1 ? s_d.perr : 1'b0;
      end
      if (!en) begin
         s_d.st = STX_IDLE;
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '{st: STX_IDLE, prev: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;
   assign data = s_q.sh;
   assign perr = s_q.perr;
   assign ferr = s_q.ferr;
   assign mpb  = s_q.mpb;
endmodule // stx_rx

/* File: rtl/stx_top.sv */
// serial transmit buffer, format control and register slave
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module stx_top
   import stx_pkg::*;
#(
   parameter int RATE_W = 8  // width of the bit period divisor
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        RXD,
   output logic             TXD,
   output logic             TXD_OE,
   output logic             SCK_OUT
);
   // refuse divisor widths the registers cannot hold
   if (RATE_W < 1 || RATE_W > 8) begin : g_chk
      $error("RATE_W must be 1 to 8");
   end

   // whole block state; every flop of the block except the receiver's sits in this one
   // struct so that the single clocked process below registers it
   // and each top output is read straight from a flop
   typedef struct packed {
      logic [7:0]        hold;   // transmit_holding
      logic [7:0]        mode;   // serial_format_mode
      logic [7:0]        ctrl;   // control bits
      logic [RATE_W-1:0] rate;   // bit period minus one
      logic [7:0]        rxbuf;  // receive_holding
      logic              hemp;   // tx_holding_empty_flag
      logic              tend;   // nothing left to send
      logic              rxf;    // receive_holding full
      logic              ferr;   // sticky framing error
      logic              perr;   // sticky parity error
      logic              mpb;    // last multidrop bit
      logic [5:0]        pre;    // prescaler counter
      logic              tick;   // prescaled baud tick
      stx_state_type     st;     // transmit sequencer
      logic [7:0]        shift;  // transmit_shift, no bus path
      logic [2:0]        bitn;   // data bit index
      logic [RATE_W-1:0] cnt;    // ticks within a bit
      logic              xbit;   // parity or multidrop bit
      logic              txd;
      logic              txd_oe;
      logic              sck;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
   } stx_state_all_type;

   stx_state_all_type s_q;  // registered state
   stx_state_all_type s_d;  // next state

   // decoded format settings; fields that a mode ignores are forced
   // off here so that the sequencer never looks at raw mode bits
   logic       sync_m;    // clocked synchronous
   logic       seven;     // 7-bit chars, async only
   logic       mp_on;     // multidrop format in force
   logic       par_on;    // parity in force
   logic       odd;       // odd parity
   logic       two_stop;  // two stop bits
   logic       te;        // transmitter enabled
   logic       stby;      // standby held
   logic [5:0] pmask;     // prescaler mask
   // bus phase helpers
   logic       acc;       // access phase, first cycle
   logic       wr;        // write commit edge
   logic       wr_hold;   // write to holding this cycle
   logic [7:0] rsel;      // read data mux
   // transmit helpers
   logic       bit_end;   // last tick of a serial bit
   logic       fin;       // character completes
   logic       last_bit;  // final data bit
   // receiver outputs
   logic       rx_done;
   logic [7:0] rx_data;
   logic       rx_perr;
   logic       rx_ferr;
   logic       rx_mpb;

   // true when the offset names a register
   // anything else, the hidden shift register included, is refused
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == STX_OFS_HOLD) || (a == STX_OFS_MODE) || (a == STX_OFS_CTRL) ||
               (a == STX_OFS_STAT) || (a == STX_OFS_RATE) || (a == STX_OFS_RXD);
   endfunction

   // format decode from the mode and control registers
   always_comb begin
      sync_m   = s_q.mode[STX_M_SYNC];
      seven    = !sync_m && s_q.mode[STX_M_CHR];
      mp_on    = !sync_m && s_q.mode[STX_M_MP] && s_q.ctrl[STX_C_MPE];
      par_on   = !sync_m && !mp_on && s_q.mode[STX_M_PE];
      odd      = par_on && s_q.mode[STX_M_ODD];
      two_stop = !sync_m && s_q.mode[STX_M_STOP];
      te       = s_q.ctrl[STX_C_TE];
      stby     = s_q.ctrl[STX_C_STBY];
      // baud source select: the tap sets how often the shared
      // prescaler ticks; a serial bit then lasts rate+1 of those
      // ticks
      case ({s_q.mode[STX_M_CKSH], s_q.mode[STX_M_CKSL]})
         2'b00:   pmask = STX_PRE_M1;
         2'b01:   pmask = STX_PRE_M4;
         2'b10:   pmask = STX_PRE_M16;
         2'b11:   pmask = STX_PRE_M64;
         default: pmask = STX_PRE_M1;
      endcase
   end

   // bus phase decode: the first access cycle is the one with ready
   // still low, which gives exactly one wait state; a write lands at
   // the following edge, where the master sees ready high
   always_comb begin
      acc     = PSEL && PENABLE && !s_q.pready;
      wr      = PSEL && PENABLE && s_q.pready && PWRITE && !s_q.pslverr;
      wr_hold = wr && PADDR == STX_OFS_HOLD && !stby;
      // read mux; the shift register is not visible
      case (PADDR)
         STX_OFS_HOLD: rsel = s_q.hold;
         STX_OFS_MODE: rsel = s_q.mode;
         STX_OFS_CTRL: rsel = s_q.ctrl;
         STX_OFS_STAT: rsel = {s_q.hemp, s_q.rxf, 1'b0, s_q.ferr, s_q.perr, s_q.tend, s_q.mpb, 1'b0};
         STX_OFS_RATE: rsel = 8'(s_q.rate);
         STX_OFS_RXD:  rsel = s_q.rxbuf;
         default:      rsel = 8'h00;
      endcase
   end

   // next state of registers, prescaler and transmitter
   always_comb begin
      s_d = s_q;
      // bus answer one cycle into the access phase
      s_d.pready = acc;
      if (acc) begin
         s_d.pslverr = !mapped(PADDR);
         s_d.prdata  = {24'h000000, rsel};
      end else begin
         s_d.pslverr = 1'b0;
      end
      // prescaled tick from the free-running counter; it is shared with
      // the receiver and never restarted, so the first bit of a frame
      // that starts from idle may be up to one tap period short
      s_d.pre  = s_q.pre + 6'h01;
      s_d.tick = (s_q.pre & pmask) == pmask;
      // register writes on the commit edge
      if (wr) begin
         case (PADDR)
            STX_OFS_HOLD: if (!stby) s_d.hold = PWDATA[7:0];
            STX_OFS_MODE: if (!stby) s_d.mode = PWDATA[7:0];
            STX_OFS_CTRL: s_d.ctrl = PWDATA[7:0];
            STX_OFS_RATE: s_d.rate = PWDATA[RATE_W-1:0];
            STX_OFS_STAT: begin
               // zero written clears the error flags
               if (!PWDATA[STX_S_FERR]) s_d.ferr = 1'b0;
               if (!PWDATA[STX_S_PERR]) s_d.perr = 1'b0;
            end
            default: ;
         endcase
      end
      // holding written means a character waits
      if (wr_hold) begin
         s_d.hemp = 1'b0;
      end
      // receive_holding read empties it
      if (acc && !PWRITE && PADDR == STX_OFS_RXD) begin
         s_d.rxf = 1'b0;
      end
      // a new character wins over the read clear; an error flag that
      // software clears in the same cycle stays clear unless this
      // character brings a new error of that kind
      if (rx_done) begin
         s_d.rxbuf = rx_data;
         s_d.rxf   = 1'b1;
         s_d.mpb   = rx_mpb;
         s_d.ferr  = s_d.ferr | rx_ferr;
         s_d.perr  = s_d.perr | rx_perr;
      end
      // bit timing inside a frame: a bit ends on the tick at which the
      // count reaches the rate value, then the count starts over
      bit_end  = s_q.tick && s_q.cnt == s_q.rate;
      last_bit = s_q.bitn == (seven ? 3'h6 : 3'h7);
      fin      = 1'b0;
      if (s_q.st != STX_IDLE && s_q.tick) begin
         s_d.cnt = bit_end ? '0 : s_q.cnt + 1'b1;
      end
      case (s_q.st)
         STX_IDLE: s_d.txd = 1'b1;
         STX_START: begin
            if (bit_end) begin
               s_d.st  = STX_DATA;
               s_d.txd = s_q.shift[0];
            end
         end
         STX_DATA: begin
            if (bit_end) begin
               s_d.shift = s_q.shift >> 1;
               s_d.bitn  = s_q.bitn + 3'h1;
               s_d.txd   = s_q.shift[1];
               if (last_bit) begin
                  if (sync_m) begin
                     fin = 1'b1;
                  end else if (mp_on || par_on) begin
                     s_d.st  = STX_PAR;
                     s_d.txd = s_q.xbit;
                  end else begin
                     s_d.st  = STX_STOP1;
                     s_d.txd = 1'b1;
                  end
               end
            end
         end
         STX_PAR: begin
            if (bit_end) begin
               s_d.st  = STX_STOP1;
               s_d.txd = 1'b1;
            end
         end
         STX_STOP1: begin
            if (bit_end) begin
               if (two_stop) begin
                  s_d.st = STX_STOP2;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         STX_STOP2: if (bit_end) fin = 1'b1;
         default: s_d.st = STX_IDLE;
      endcase
      // load holding into shift at the end of a character
      // or from idle; a write in the same cycle waits one clock,
      // since the load would set the empty flag that the write
      // clears, and the character just written would be lost
      if ((s_q.st == STX_IDLE || fin) && te && !s_q.hemp && !wr_hold && !stby) begin
         s_d.shift = seven ? {1'b0, s_q.hold[6:0]} : s_q.hold;
         s_d.xbit  = mp_on ? s_q.ctrl[STX_C_MPBT] : stx_parity(s_q.hold, seven, odd);
         s_d.hemp  = 1'b1;
         s_d.tend  = 1'b0;
         s_d.bitn  = 3'h0;
         s_d.cnt   = '0;
         s_d.st    = sync_m ? STX_DATA : STX_START;
         s_d.txd   = sync_m ? s_q.hold[0] : 1'b0;
      end else if (fin) begin
         // nothing waiting: shift register left untouched
         // the line returns to its idle level after the last stop
         s_d.st   = STX_IDLE;
         s_d.tend = 1'b1;
         s_d.txd  = 1'b1;
      end
      // transmit enable low stops the frame and frees the pin
      // a character still waiting in holding goes out once enable returns
      if (!te) begin
         s_d.st   = STX_IDLE;
         s_d.txd  = 1'b1;
         s_d.tend = 1'b1;
      end
      s_d.txd_oe = s_d.ctrl[STX_C_TE];
      // serial clock low in the first half of each sync bit
      // so the partner can take the data on the rising clock edge
      s_d.sck = !(sync_m && s_d.st == STX_DATA && s_d.cnt <= (s_q.rate >> 1));
      // standby returns holding and format to reset values;
      // control and rate are kept so software can leave standby
      if (s_d.ctrl[STX_C_STBY]) begin
         s_d.hold = STX_RST_HOLD;
         s_d.mode = STX_RST_MODE;
         s_d.hemp = 1'b1;
         s_d.st   = STX_IDLE;
         s_d.txd  = 1'b1;
         s_d.tend = 1'b1;
         s_d.sck  = 1'b1;
      end
   end

   // state register
   // reset puts holding to all ones and the format to zero
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         s_q <= '{hold: STX_RST_HOLD, mode: STX_RST_MODE, ctrl: STX_RST_CTRL,
                  rate: RATE_W'(STX_RST_RATE), rxbuf: STX_RST_RXD, hemp: 1'b1,
                  tend: 1'b1, st: STX_IDLE, txd: 1'b1, sck: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // async receiver, runs in async mode while receive enable is set and standby is off
   // it shares the prescaled tick and the rate with the transmitter
   stx_rx #(
      .RATE_W (RATE_W)
   ) u_rx (
      .clk      (CLK_SYS),
      .rst      (RST),
      .en       (!sync_m && s_q.ctrl[STX_C_RE] && !stby),
      .pre_tick (s_q.tick),
      .rate     (s_q.rate),
      .seven    (seven),
      .par_en   (par_on),
      .odd      (odd),
      .mp_en    (mp_on),
      .rxd      (RXD),
      .done     (rx_done),
      .data     (rx_data),
      .perr     (rx_perr),
      .ferr     (rx_ferr),
      .mpb      (rx_mpb)
   );

   // outputs straight from the state register
   // no output passes through logic after its flop
   assign PRDATA  = s_q.prdata;
   assign PREADY  = s_q.pready;
   assign PSLVERR = s_q.pslverr;
   assign TXD     = s_q.txd;
   assign TXD_OE  = s_q.txd_oe;
   assign SCK_OUT = s_q.sck;
endmodule // stx_top

/* File: tb/stx_top_assertions.sv */
// checker: bus timing and transmit pin relations at the top ports
`timescale 1ns/100ps
module stx_top_chk
   import stx_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        RXD,
   input wire logic        TXD,
   input wire logic        TXD_OE,
   input wire logic        SCK_OUT
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // one wait state, then a single-cycle answer
   ready_wait_a: assert property ($rose(PENABLE) && PSEL |=> PREADY) else $error("ready late");
   ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
   ready_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
   upper_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper read bits set");
   err_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
   // nothing beyond the last register, the shift register included
   unmapped_err_a: assert property ($rose(PENABLE) && PSEL && PADDR > STX_OFS_RXD |=> PSLVERR)
      else $error("unmapped not refused");
   // pin released and idle while transmit is off
   txd_idle_a: assert property (!TXD_OE && !$past(TXD_OE) |-> TXD) else $error("txd active");
   te_on_a: assert property (PREADY && PWRITE && PADDR == STX_OFS_CTRL && PWDATA[STX_C_TE] |->
      ##[1:2] TXD_OE) else $error("pin not driven");
   te_off_a: assert property (PREADY && PWRITE && PADDR == STX_OFS_CTRL && !PWDATA[STX_C_TE] |->
      ##[1:2] !TXD_OE) else $error("pin not released");
endmodule // stx_top_chk

bind stx_top stx_top_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD), .TXD_OE(TXD_OE), .SCK_OUT(SCK_OUT));

/* File: tb/stx_partner.sv */
// far-side serial device: captures asynchronous frames from the line
`timescale 1ns/100ps
module stx_partner (
   input  wire logic       clk,
   input  wire logic       txd,
   input  wire logic [3:0] nbits,  // bits after start, stops included
   input  wire logic [7:0] bitclk, // clocks per bit
   output logic            rxd,    // idles high, nothing sent back
   output logic [11:0]     frame,
   output logic [7:0]      cnt,
   output logic [15:0]     gap     // clocks between two starts
);
   // sample mid-bit after each falling start edge
   initial begin
      time last;
      int  i;
      rxd = 1'b1;
      frame = 12'h000;
      cnt = 8'h00;
      gap = 16'h0000;
      last = 0;
      forever begin
         @(posedge clk);
         if (txd === 1'b0) begin
            gap = 16'(($time - last) / 20);
            last = $time;
            repeat (bitclk / 2) @(posedge clk);
            frame = 12'h000;
            for (i = 0; i < nbits; i++) begin
               repeat (bitclk) @(posedge clk);
               frame[i] = txd;
            end
            cnt = cnt + 8'h01;
         end
      end
   end
endmodule // stx_partner

/* File: tb/tb_stx_top.sv */
// testbench: registers, frame formats, pacing and clock select
`timescale 1ns/100ps
module tb_stx_top
   import stx_pkg::*;
;
   localparam logic [7:0] MODES [9] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08, 8'h74, 8'h04, 8'h58, 8'h68};
   localparam logic [7:0] CTRLS [9] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h29, 8'h20, 8'h20, 8'h20};
   logic        clk_sys, rst, psel, penable, pwrite, txd, txd_oe, sck_out, rxd, pready, pslverr, err, s;
   logic [7:0]  paddr, cnt, bitclk, d, d2;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] frame, ef;
   logic [15:0] gap;
   logic [3:0]  nbits;
   integer      seed = 32'h4a2a524d;
   int          errors = 0, n_checks = 0, n, i;

   stx_top DUT (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RXD(rxd), .TXD(txd), .TXD_OE(txd_oe), .SCK_OUT(sck_out));
   stx_partner u_far (.clk(clk_sys), .txd(txd), .nbits(nbits), .bitclk(bitclk), .rxd(rxd),
      .frame(frame), .cnt(cnt), .gap(gap));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one bus transfer, held until ready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] dw);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, dw};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_cnt(input logic [7:0] want);
      while (cnt !== want) begin
         @(posedge clk_sys);
      end
   endtask

   // bits after the start bit, in line order
   function automatic logic [11:0] exp_frame(input logic [7:0] m, c, dv, output int nb);
      logic [11:0] f;
      logic        mp;
      f = 12'h000;
      nb = 0;
      for (int j = 0; j < (m[6] ? 7 : 8); j++) f[nb++] = dv[j];
      mp = m[2] & c[3];
      if (mp | m[5]) f[nb++] = mp ? c[0] : (^dv[6:0]) ^ (dv[7] & ~m[6]) ^ m[4];
      f[nb++] = 1'b1;
      if (m[3]) f[nb++] = 1'b1;
      return f;
   endfunction

   task automatic give_verdict;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge clk_sys);
      errors++;
      give_verdict;
   end

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      nbits = 4'd9;
      bitclk = 8'd4;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, STX_OFS_HOLD, 8'h00);
      chk(rd, 32'hFF);
      apb(1'b0, STX_OFS_MODE, 8'h00);
      chk(rd, 32'h0);
      apb(1'b0, 8'h18, 8'h00);
      chk(32'(err), 32'h1);
      apb(1'b1, STX_OFS_RATE, 8'h03);
      // nine format settings, each with a random character
      for (i = 0; i < 9; i++) begin
         apb(1'b1, STX_OFS_CTRL, CTRLS[i]);
         apb(1'b1, STX_OFS_MODE, MODES[i]);
         d = 8'($random(seed));
         ef = exp_frame(MODES[i], CTRLS[i], d, n);
         nbits = 4'(n);
         apb(1'b1, STX_OFS_HOLD, d);
         wait_cnt(cnt + 8'h01);
         chk(32'(frame), 32'(ef));
      end
      chk(32'(txd_oe), 32'h1);
      // refill during shifting: two frames with no gap, then silence
      apb(1'b1, STX_OFS_MODE, 8'h00);
      nbits = 4'd9;
      d = 8'($random(seed));
      d2 = 8'($random(seed));
      apb(1'b1, STX_OFS_HOLD, d);
      apb(1'b1, STX_OFS_HOLD, d2);
      wait_cnt(cnt + 8'h01);
      chk(32'(frame), 32'(exp_frame(8'h00, 8'h20, d, n)));
      wait_cnt(cnt + 8'h01);
      chk(32'(frame), 32'(exp_frame(8'h00, 8'h20, d2, n)));
      chk(32'(gap), 32'd40);
      n = cnt;
      repeat (100) @(posedge clk_sys);
      chk(32'(cnt), 32'(n));
      // length of data bit 0 for each prescaler tap; the start bit is
      // not timed, the free-running prescaler may clip it
      apb(1'b1, STX_OFS_RATE, 8'h00);
      for (i = 0; i < 4; i++) begin
         bitclk = 8'(1 << (2 * i));
         apb(1'b1, STX_OFS_MODE, 8'(i));
         apb(1'b1, STX_OFS_HOLD, 8'h01);
         n = 0;
         while (txd !== 1'b0 && n < 500) begin
            @(posedge clk_sys);
            n++;
         end
         n = 0;
         while (txd === 1'b0 && n < 500) begin
            @(posedge clk_sys);
            n++;
         end
         n = 0;
         while (txd === 1'b1 && n < 500) begin
            @(posedge clk_sys);
            n++;
         end
         chk(32'(n), 32'(1 << (2 * i)));
         wait_cnt(cnt + 8'h01);
      end
      // synchronous mode: eight clock pulses per character
      apb(1'b1, STX_OFS_RATE, 8'h03);
      apb(1'b1, STX_OFS_MODE, 8'h80);
      d = 8'($random(seed));
      apb(1'b1, STX_OFS_HOLD, d);
      n = 0;
      s = sck_out;
      repeat (200) begin
         @(posedge clk_sys);
         if (s === 1'b1 && sck_out === 1'b0) n++;
         s = sck_out;
      end
      chk(32'(n), 32'd8);
      apb(1'b1, STX_OFS_CTRL, 8'h00);
      repeat (3) @(posedge clk_sys);
      chk(32'({txd_oe, txd}), 32'h1);
      // random read-back of both registers
      for (i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         apb(1'b1, STX_OFS_HOLD, d);
         apb(1'b0, STX_OFS_HOLD, 8'h00);
         chk(rd, {24'h0, d});
         d = 8'($random(seed));
         apb(1'b1, STX_OFS_MODE, d);
         apb(1'b0, STX_OFS_MODE, 8'h00);
         chk(rd, {24'h0, d});
      end
      // standby returns holding and format to their reset values
      apb(1'b1, STX_OFS_CTRL, 8'h02);
      apb(1'b0, STX_OFS_HOLD, 8'h00);
      chk(rd, 32'hFF);
      apb(1'b0, STX_OFS_MODE, 8'h00);
      chk(rd, 32'h0);
      give_verdict;
   end
endmodule // tb_stx_top
